// File: logic/acd_pkg.sv
// Purpose: shared constants and types for the amplifier channel control bank
// Assumes: byte-wide register port driven by the control-bus engine
// Notes: timing figures are plain defaults, tune via top parameters
package acd_pkg;

	// register offsets
	localparam logic [7:0] ACD_ADDR_STATE_SEL = 8'h04;
	localparam logic [7:0] ACD_ADDR_VOL_CH1 = 8'h05;
	localparam logic [7:0] ACD_ADDR_VOL_CH2 = 8'h06;
	localparam logic [7:0] ACD_ADDR_VOL_CH3 = 8'h07;
	localparam logic [7:0] ACD_ADDR_VOL_CH4 = 8'h08;
	localparam logic [7:0] ACD_ADDR_CHECK_CTL = 8'h09;
	localparam logic [7:0] ACD_ADDR_THR_CH12 = 8'h0A;
	localparam logic [7:0] ACD_ADDR_THR_CH34 = 8'h0B;
	localparam logic [7:0] ACD_ADDR_RESULT_CH12 = 8'h0C;
	localparam logic [7:0] ACD_ADDR_STATE_RPT = 8'h0F;

	// reset values
	localparam logic [7:0] ACD_RST_STATE_SEL = 8'h55;
	localparam logic [7:0] ACD_RST_VOLUME = 8'hCF;
	localparam logic [7:0] ACD_RST_CHECK_CTL = 8'h00;
	localparam logic [7:0] ACD_RST_THR = 8'h11;
	localparam logic [7:0] ACD_RST_RESULT = 8'h00;

	// volume codes below this mute the channel
	localparam logic [7:0] ACD_VOL_MUTE_BELOW = 8'h07;

	// check control field positions
	localparam int ACD_CTL_ABORT = 7;
	localparam int ACD_CTL_RAMP_X2 = 6;
	localparam int ACD_CTL_SETTLE_X2 = 5;
	localparam int ACD_CTL_LINE_OUT = 1;
	localparam int ACD_CTL_AUTO_SKIP = 0;

	// channel operating states
	localparam logic [1:0] ACD_ST_PLAY = 2'h0;
	localparam logic [1:0] ACD_ST_HIZ = 2'h1;
	localparam logic [1:0] ACD_ST_MUTE = 2'h2;
	localparam logic [1:0] ACD_ST_CHECK = 2'h3;

	// timing
	localparam int ACD_CLK_PERIOD_NS = 4;
	localparam int ACD_RAMP_TIME_NS = 10000;
	localparam int ACD_SETTLE_TIME_NS = 5000;
	localparam int ACD_RAMP_CYC = ACD_RAMP_TIME_NS / ACD_CLK_PERIOD_NS;
	localparam int ACD_SETTLE_CYC = ACD_SETTLE_TIME_NS / ACD_CLK_PERIOD_NS;
	localparam int ACD_CNT_W = 16;

	typedef enum logic [3:0] {
		ACD_IDLE = 4'b0001,
		ACD_RAMP = 4'b0010,
		ACD_SETTLE = 4'b0100,
		ACD_MEASURE = 4'b1000
	} acd_phase_t;

	// load check result of one channel
	typedef struct packed {
		logic short_to_ground_flag;
		logic short_to_supply_flag;
		logic open_load_flag;
		logic shorted_load_flag;
	} acd_meas_t;

	typedef struct packed {
		logic [3:0][1:0] sel;
		logic [3:0][1:0] act;
		logic [3:0][7:0] vol;
		logic [3:0] mute;
		logic [7:0] ctl;
		logic [3:0][3:0] thr;
		logic [7:0] result;
		acd_phase_t [3:0] phase;
		logic [3:0][ACD_CNT_W-1:0] cnt;
		logic [7:0] rdata;
	} acd_state_t;

endpackage

// File: logic/acd_channel_bank.sv
// Purpose: channel state, volume and load check control bank of a 4-channel amplifier
// Assumes: register port strobes come from the control-bus engine, synchronous to CLOCK
// Notes: channel index 0 is channel one; field order in packed buses is ch4..ch1, except CH_STATE, where index 3 is channel one
//        abort is a level; while it is set no load check starts on any channel
// Behaviour
// - 2-bit state per channel, resets to high impedance
// - four independent 8-bit read/write volume registers
// - volume at 0x05..0x08, reset 0xCF
// - volume code below 0x07 mutes channel
// - abort bit stops running load check
// - bits 6 and 5 double ramp, settle
// - bit 1 enables line output checking
// - auto-skip clear: check on leaving hi-z, fault
// - auto-skip set: check only on request
// - 4-bit short threshold per channel, reset 0001
// - thresholds packed at 0x0A, 0x0B, upper nibble first
// - result register 0x0C, four flags ch1, ch2
// - result flag set when fault detected
// - state report at 0x0F, same encoding
// - state selector at 0x04, reset 0x55
`timescale 1ns/1ps

module acd_channel_bank
	import acd_pkg::*;
#(
	parameter int RAMP_CYCLES = ACD_RAMP_CYC,
	parameter int SETTLE_CYCLES = ACD_SETTLE_CYC
)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic [3:0] CH_FAULT,
	input wire acd_meas_t [3:0] MEAS_RESULT,
	output logic [3:0][1:0] CH_STATE,
	output logic [3:0][7:0] CH_VOLUME,
	output logic [3:0] CH_MUTE,
	output logic [3:0][3:0] SHORT_THRESHOLD,
	output logic LINE_OUT_CHECK,
	output logic [3:0] CHECK_RAMP,
	output logic [3:0] CHECK_SETTLE,
	output logic [3:0] CHECK_MEASURE
);

	acd_state_t state_reg;
	acd_state_t state_next;

	logic [ACD_CNT_W-1:0] ramp_load;
	logic [ACD_CNT_W-1:0] settle_load;
	logic [ACD_CNT_W-1:0] ramp_base;
	logic [ACD_CNT_W-1:0] settle_base;
	logic abort;
	logic auto_skip;

	assign ramp_base = ACD_CNT_W'(RAMP_CYCLES);
	assign settle_base = ACD_CNT_W'(SETTLE_CYCLES);
	assign abort = state_reg.ctl[ACD_CTL_ABORT];
	assign auto_skip = state_reg.ctl[ACD_CTL_AUTO_SKIP];

	// counters run down to zero, so load one less than the length
	always_comb
	begin
		ramp_load = ramp_base - 16'h0001;
		settle_load = settle_base - 16'h0001;
		if (state_reg.ctl[ACD_CTL_RAMP_X2])
		begin
			ramp_load = {ramp_base[ACD_CNT_W-2:0], 1'b0} - 16'h0001;
		end
		if (state_reg.ctl[ACD_CTL_SETTLE_X2])
		begin
			settle_load = {settle_base[ACD_CNT_W-2:0], 1'b0} - 16'h0001;
		end
	end

	always_comb
	begin
		logic [1:0] sel_new;
		logic start;
		logic sel_wr;
		logic [1:0] rest;
		state_next = state_reg;
		sel_new = 2'h0;
		start = 1'b0;
		sel_wr = REG_WR && (REG_ADDR == ACD_ADDR_STATE_SEL);
		rest = 2'h0;

		// register writes
		if (REG_WR)
		begin
			if (REG_ADDR == ACD_ADDR_STATE_SEL)
			begin
				state_next.sel = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH1)
			begin
				state_next.vol[0] = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH2)
			begin
				state_next.vol[1] = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH3)
			begin
				state_next.vol[2] = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH4)
			begin
				state_next.vol[3] = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_CHECK_CTL)
			begin
				state_next.ctl = REG_WDATA;
			end
			else if (REG_ADDR == ACD_ADDR_THR_CH12)
			begin
				state_next.thr[0] = REG_WDATA[7:4];
				state_next.thr[1] = REG_WDATA[3:0];
			end
			else if (REG_ADDR == ACD_ADDR_THR_CH34)
			begin
				state_next.thr[2] = REG_WDATA[7:4];
				state_next.thr[3] = REG_WDATA[3:0];
			end
		end

		for (int i = 0; i < 4; i++)
		begin
			// selector fields are packed ch1 in the top bits
			sel_new = state_next.sel[3-i];
			state_next.mute[i] = state_next.vol[i] < ACD_VOL_MUTE_BELOW;
			rest = sel_new;
			if (sel_new == ACD_ST_CHECK)
			begin
				rest = ACD_ST_HIZ;
			end
			start = 1'b0;
			if (sel_wr && (sel_new != state_reg.sel[3-i]))
			begin
				if (sel_new == ACD_ST_CHECK)
				begin
					start = 1'b1;
				end
				else if ((sel_new != ACD_ST_HIZ) && !auto_skip)
				begin
					// leaving high impedance is judged on the actual state
					if (state_reg.act[3-i] == ACD_ST_HIZ)
					begin
						start = 1'b1;
					end
				end
			end
			// a fault only restarts a channel that is driving its load
			if (CH_FAULT[i] && !auto_skip && (state_reg.act[3-i] != ACD_ST_HIZ))
			begin
				start = 1'b1;
			end

			// a start request meeting a set abort bit is dropped, not queued
			case (state_reg.phase[i])
				ACD_IDLE:
				begin
					if (start && !abort)
					begin
						state_next.phase[i] = ACD_RAMP;
						state_next.cnt[i] = ramp_load;
						state_next.act[3-i] = ACD_ST_CHECK;
					end
					else
					begin
						// with no check running the report follows the selector, a check selection reading as high impedance
						state_next.act[3-i] = rest;
					end
				end
				ACD_RAMP:
				begin
					if (abort)
					begin
						state_next.phase[i] = ACD_IDLE;
						state_next.act[3-i] = ACD_ST_HIZ;
					end
					else if (state_reg.cnt[i] == '0)
					begin
						state_next.phase[i] = ACD_SETTLE;
						state_next.cnt[i] = settle_load;
					end
					else
					begin
						state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
					end
				end
				ACD_SETTLE:
				begin
					if (abort)
					begin
						state_next.phase[i] = ACD_IDLE;
						state_next.act[3-i] = ACD_ST_HIZ;
					end
					else if (state_reg.cnt[i] == '0)
					begin
						state_next.phase[i] = ACD_MEASURE;
					end
					else
					begin
						state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
					end
				end
				ACD_MEASURE:
				begin
					// sample the measurement and leave for the requested state
					state_next.phase[i] = ACD_IDLE;
					if (abort)
					begin
						state_next.act[3-i] = ACD_ST_HIZ;
					end
					else
					begin
						state_next.act[3-i] = rest;
						// only channels one and two keep a result
						if (i == 0)
						begin
							state_next.result[7:4] = MEAS_RESULT[0];
						end
						else if (i == 1)
						begin
							state_next.result[3:0] = MEAS_RESULT[1];
						end
					end
				end
				default:
				begin
					state_next.phase[i] = ACD_IDLE;
					state_next.act[3-i] = ACD_ST_HIZ;
				end
			endcase
		end

		// register reads, answered one cycle after the strobe
		if (REG_RD)
		begin
			if (REG_ADDR == ACD_ADDR_STATE_SEL)
			begin
				state_next.rdata = state_reg.sel;
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH1)
			begin
				state_next.rdata = state_reg.vol[0];
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH2)
			begin
				state_next.rdata = state_reg.vol[1];
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH3)
			begin
				state_next.rdata = state_reg.vol[2];
			end
			else if (REG_ADDR == ACD_ADDR_VOL_CH4)
			begin
				state_next.rdata = state_reg.vol[3];
			end
			else if (REG_ADDR == ACD_ADDR_CHECK_CTL)
			begin
				state_next.rdata = state_reg.ctl;
			end
			else if (REG_ADDR == ACD_ADDR_THR_CH12)
			begin
				state_next.rdata = {state_reg.thr[0], state_reg.thr[1]};
			end
			else if (REG_ADDR == ACD_ADDR_THR_CH34)
			begin
				state_next.rdata = {state_reg.thr[2], state_reg.thr[3]};
			end
			else if (REG_ADDR == ACD_ADDR_RESULT_CH12)
			begin
				state_next.rdata = state_reg.result;
			end
			else if (REG_ADDR == ACD_ADDR_STATE_RPT)
			begin
				state_next.rdata = state_reg.act;
			end
			else
			begin
				state_next.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			// selector and report both start with every channel in high impedance
			state_reg.sel <= ACD_RST_STATE_SEL;
			state_reg.act <= ACD_RST_STATE_SEL;
			state_reg.vol[0] <= ACD_RST_VOLUME;
			state_reg.vol[1] <= ACD_RST_VOLUME;
			state_reg.vol[2] <= ACD_RST_VOLUME;
			state_reg.vol[3] <= ACD_RST_VOLUME;
			state_reg.mute <= 4'h0;
			state_reg.ctl <= ACD_RST_CHECK_CTL;
			state_reg.thr[0] <= ACD_RST_THR[7:4];
			state_reg.thr[1] <= ACD_RST_THR[3:0];
			state_reg.thr[2] <= ACD_RST_THR[7:4];
			state_reg.thr[3] <= ACD_RST_THR[3:0];
			state_reg.result <= ACD_RST_RESULT;
			state_reg.phase[0] <= ACD_IDLE;
			state_reg.phase[1] <= ACD_IDLE;
			state_reg.phase[2] <= ACD_IDLE;
			state_reg.phase[3] <= ACD_IDLE;
			state_reg.cnt[0] <= '0;
			state_reg.cnt[1] <= '0;
			state_reg.cnt[2] <= '0;
			state_reg.cnt[3] <= '0;
			state_reg.rdata <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign REG_RDATA = state_reg.rdata;
	assign CH_STATE = state_reg.act;
	assign CH_VOLUME = state_reg.vol;
	assign CH_MUTE = state_reg.mute;
	assign SHORT_THRESHOLD = state_reg.thr;
	assign LINE_OUT_CHECK = state_reg.ctl[ACD_CTL_LINE_OUT];

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			CHECK_RAMP[i] = state_reg.phase[i][1];
			CHECK_SETTLE[i] = state_reg.phase[i][2];
			CHECK_MEASURE[i] = state_reg.phase[i][3];
		end
	end

endmodule // acd_channel_bank

// File: tb/acd_bank_assertions.sv
// Purpose: port checks of the channel bank
// Assumes: bench ramp count passed through bind
// Notes: phase timing watched on channel one
`timescale 1ns/1ps
module acd_bank_assertions
#(parameter int RAMP_CYCLES = 4)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic [3:0][1:0] CH_STATE,
	input wire logic [3:0][7:0] CH_VOLUME,
	input wire logic [3:0] CH_MUTE,
	input wire logic [3:0][3:0] SHORT_THRESHOLD,
	input wire logic LINE_OUT_CHECK,
	input wire logic [3:0] CHECK_RAMP,
	input wire logic [3:0] CHECK_SETTLE,
	input wire logic [3:0] CHECK_MEASURE
);
	logic [7:0] ctl_q;
	logic [15:0] cnt_q;
	logic busy;
	logic wr4;
	assign busy = CHECK_RAMP[0] | CHECK_SETTLE[0] | CHECK_MEASURE[0];
	assign wr4 = REG_WR && REG_ADDR == 8'h04 && !busy;
	// shadow of the check control byte and ramp length counter
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ctl_q <= 8'h00;
		else if (REG_WR && REG_ADDR == 8'h09)
			ctl_q <= REG_WDATA;
		cnt_q <= (RST_N && CHECK_RAMP[0]) ? cnt_q + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	a_mute_level: assert property (CH_MUTE == {CH_VOLUME[3] < 8'h07,
		CH_VOLUME[2] < 8'h07, CH_VOLUME[1] < 8'h07, CH_VOLUME[0] < 8'h07})
		else $error("mute flag wrong");
	a_vol_write: assert property (REG_WR && REG_ADDR == 8'h05 |=>
		CH_VOLUME[0] == $past(REG_WDATA)) else $error("volume write lost");
	a_vol_read: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h06 |=>
		REG_RDATA == $past(CH_VOLUME[1])) else $error("volume read wrong");
	a_thr_pack: assert property (REG_WR && REG_ADDR == 8'h0A |=>
		{SHORT_THRESHOLD[0], SHORT_THRESHOLD[1]} == $past(REG_WDATA)) else $error("thr");
	a_line_out: assert property (REG_WR && REG_ADDR == 8'h09 |=>
		LINE_OUT_CHECK == $past(REG_WDATA[1])) else $error("line out bit");
	a_ramp_len: assert property ($fell(CHECK_RAMP[0]) && !ctl_q[7] |->
		cnt_q == 16'(RAMP_CYCLES * (ctl_q[6] ? 2 : 1)) && CHECK_SETTLE[0])
		else $error("ramp length");
	a_check_state: assert property (busy |-> CH_STATE[3] == 2'h3) else $error("state");
	// the abort bit lands one edge after the write and stops the check one edge later
	a_abort_stop: assert property (REG_WR && REG_ADDR == 8'h09 && REG_WDATA[7] |-> ##2
		CHECK_RAMP == 4'h0 && CHECK_SETTLE == 4'h0 && CHECK_MEASURE == 4'h0)
		else $error("abort ignored");
	a_skip_hold: assert property (wr4 && ctl_q[0] && REG_WDATA[7:6] != 2'h3 |=>
		!CHECK_RAMP[0]) else $error("auto check ran");
	a_auto_run: assert property (wr4 && ctl_q[1:0] != 2'h1 && !ctl_q[7] && !ctl_q[0] &&
		CH_STATE[3] == 2'h1 && REG_WDATA[7:6] == 2'h0 |=> CHECK_RAMP[0])
		else $error("auto check missing");
	c_measure: cover property ($fell(CHECK_MEASURE[0]));
	c_abort: cover property (REG_WR && REG_ADDR == 8'h09 && REG_WDATA[7]);
	c_mute: cover property ($rose(CH_MUTE[0]));
endmodule // acd_bank_assertions

bind acd_channel_bank acd_bank_assertions #(.RAMP_CYCLES(RAMP_CYCLES))
	acd_bank_assertions_inst (.*);

// File: tb/acd_host_model.sv
// Purpose: host side of the register port and load sense stub
// Assumes: strobes launched on the falling clock edge
// Notes: released address and data lines are inverted
`timescale 1ns/1ps
module acd_host_model
	import acd_pkg::*;
(
	input wire logic CLOCK,
	input wire logic [7:0] REG_RDATA,
	output logic [7:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WR,
	output logic REG_RD,
	output logic [3:0] CH_FAULT,
	output acd_meas_t [3:0] MEAS_RESULT
);
	initial
	begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		CH_FAULT = 4'h0;
		MEAS_RESULT = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_WDATA = (a == 8'h09) ? (d & 8'hE3) : d;
		REG_WR = 1'b1;
		@(negedge CLOCK);
		REG_WR = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~REG_WDATA;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLOCK);
		REG_RD = 1'b0;
		REG_ADDR = ~a;
		d = REG_RDATA;
	endtask
	task automatic flt(input logic [3:0] m);
		@(negedge CLOCK);
		CH_FAULT = m;
		@(negedge CLOCK);
		CH_FAULT = 4'h0;
	endtask
	task automatic meas(input int c, input acd_meas_t v);
		MEAS_RESULT[c] = v;
	endtask
endmodule // acd_host_model

// File: tb/acd_channel_bank_tb.sv
// Purpose: register level test of the channel bank
// Assumes: ramp 4 and settle 3 cycles
// Notes: host model owns every strobe
`timescale 1ns/1ps
module acd_channel_bank_tb
	import acd_pkg::*;
;
	logic CLOCK, RST_N, REG_WR, REG_RD, LINE_OUT_CHECK;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic [3:0] CH_FAULT, CH_MUTE, CHECK_RAMP, CHECK_SETTLE, CHECK_MEASURE;
	acd_meas_t [3:0] MEAS_RESULT;
	logic [3:0][1:0] CH_STATE;
	logic [3:0][7:0] CH_VOLUME;
	logic [3:0][3:0] SHORT_THRESHOLD;
	int err_total = 0;
	int check_count = 0;
	int r, s;
	logic [7:0] rv;
	logic [7:0] rst_v [10] = '{8'h55, 8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'h00, 8'h11, 8'h11, 8'h00, 8'h55};
	logic [7:0] vols [4] = '{8'h06, 8'h07, 8'hFF, 8'h00};
	acd_channel_bank #(.RAMP_CYCLES(4), .SETTLE_CYCLES(3)) acd_channel_bank_inst (.*);
	acd_host_model acd_host_model_inst (.*);
	initial
	begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acd_host_model_inst.wr(a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		acd_host_model_inst.rd(a, rv);
		chk($sformatf("reg %h", a), rv, e);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		RST_N = 1'b0;
		repeat (8) @(negedge CLOCK);
		RST_N = 1'b1;
		for (int i = 0; i < 10; i++)
			rchk(i == 9 ? 8'h0F : 8'(8'h04 + i), rst_v[i]);
		rchk(8'h20, 8'h00);
		$display("test 1 done");
		for (int i = 0; i < 4; i++)
			wr(8'(8'h05 + i), vols[i]);
		chk("mute", {4'h0, CH_MUTE}, 8'h09);
		for (int i = 0; i < 4; i++)
			rchk(8'(8'h05 + i), vols[i]);
		wr(8'h0A, 8'h90);
		chk("thr", {SHORT_THRESHOLD[0], SHORT_THRESHOLD[1]}, 8'h90);
		wr(8'h0C, 8'hFF);
		rchk(8'h0C, 8'h00);
		$display("test 2 done");
		wr(8'h09, 8'h03);
		chk("line", {7'h00, LINE_OUT_CHECK}, 8'h01);
		wr(8'h04, 8'h62);
		chk("idle", {4'h0, CHECK_RAMP}, 8'h00);
		rchk(8'h0F, 8'h62);
		acd_host_model_inst.meas(0, 4'hA);
		acd_host_model_inst.meas(1, 4'h5);
		wr(8'h09, 8'h41);
		wr(8'h04, 8'hE2);
		r = 0;
		s = 0;
		for (int n = 0; n < 50 && CHECK_MEASURE[0] !== 1'b1; n++)
		begin
			r += int'(CHECK_RAMP[0] === 1'b1);
			s += int'(CHECK_SETTLE[0] === 1'b1);
			@(negedge CLOCK);
		end
		if (CHECK_MEASURE[0] !== 1'b1)
		begin
			err_total++;
			test_done();
		end
		chk("state", {6'h00, CH_STATE[3]}, 8'h03);
		chk("ramp", 8'(r), 8'h08);
		chk("settle", 8'(s), 8'h03);
		rchk(8'h0C, 8'hA0);
		rchk(8'h0F, 8'h62);
		$display("test 3 done");
		wr(8'h09, 8'h00);
		wr(8'h04, 8'h22);
		chk("auto", {4'h0, CHECK_RAMP}, 8'h01);
		wr(8'h09, 8'h80);
		// the stored abort bit stops the check at the following edge
		@(negedge CLOCK);
		chk("abort", {4'h0, CHECK_RAMP}, 8'h00);
		wr(8'h09, 8'h00);
		acd_host_model_inst.flt(4'h4);
		chk("fault", {4'h0, CHECK_RAMP}, 8'h04);
		repeat (12) @(negedge CLOCK);
		rchk(8'h0F, 8'h22);
		$display("test 4 done");
		test_done();
	end
endmodule // acd_channel_bank_tb
